// ---- cbt_core.sv ----
// can transmit abort, error escalation and bit timing engine
// Functional notes
// - clearing a buffer request bit dequeues that buffer
// - writing abort_all bit 12 aborts every pending buffer that does not complete
// - abort applies only when buffer is not actively transmitting
// - processed abort sets aborted flag, never the buffer irq flag
// - each ack, form or bit error adds one to counter, holding at 511; a counter write in the same cycle wins
// - count above 96 sets error irq and warning flags
// - free unscheduled buffer raises transmit interrupt and its buffer flag
// - count above 127 enters error passive and sets passive flag
// - count above 255 enters bus off and sets bus off flag
// - bit time is whole quanta, clamped to 8 through 25
// - quantum is two times prescaler plus one clocks
// - module clock is instruction clock or four times it, by select
// - propagation segment 1 to 8 quanta from bits 2:0
// - phase one 1 to 8 quanta from bits 5:3, sample at end
// - phase two from bits 10:8, or max of phase one and 2
// - triple sampling takes majority of three half-quantum samples
// - hard sync on falling edge while idle restarts sync segment
// - no resync within a bit time holding a hard sync
// - edges outside sync segment adjust phase one or phase two
// - jump width 1 to 4 quanta bounds each adjustment
`timescale 1ns/1ps
`default_nettype none
module cbt_core (
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        enable_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        write_in,
    input  wire logic        read_in,
    output logic [15:0]      rdata_out,
    input  wire logic        rx_pin_in,
    input  wire logic [2:0]  tx_active_in,
    input  wire logic [2:0]  tx_done_in,
    input  wire logic        tx_err_in,
    input  wire logic        bus_idle_in,
    output logic [2:0]       tx_request_out,
    output logic             tx_irq_out,
    output logic             err_irq_out,
    output logic             sample_tick_out,
    output logic             rx_bit_out,
    output logic             clk_div4_sel_out
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [15:0] ctrl_q;
    logic [15:0] cfg1_q;
    logic [15:0] cfg2_q;
    logic [2:0]  req_q;
    logic [2:0]  aborted_q;
    logic [2:0]  bufirq_q;
    logic        abort_pend_q;
    logic        err_irq_q;
    logic        warn_q;
    logic        passive_q;
    logic        bus_off_q;
    logic [8:0]  err_cnt_q;
    logic [15:0] rdata_q;
    logic        tx_irq_q;
    logic        div4_q;

    wire wr_ctrl  = write_in && addr_in == cbt_pkg::ADDR_MODULE_CONTROL;
    wire wr_flags = write_in && addr_in == cbt_pkg::ADDR_INT_FLAG;
    wire wr_cfg1  = write_in && addr_in == cbt_pkg::ADDR_TIMING_CONFIG1;
    wire wr_cfg2  = write_in && addr_in == cbt_pkg::ADDR_TIMING_CONFIG2;
    wire wr_txc   = write_in && addr_in == cbt_pkg::ADDR_TX_CONTROL;
    wire wr_txs   = write_in && addr_in == cbt_pkg::ADDR_TX_STATUS;
    wire wr_cnt   = write_in && addr_in == cbt_pkg::ADDR_ERR_COUNT;

    // ----------------------------------------------------------------
    // abort handling
    // ----------------------------------------------------------------
    wire abort_all_wr = wr_ctrl && wdata_in[cbt_pkg::ABORT_ALL_BIT];
    wire abort_req    = abort_all_wr || abort_pend_q;
    // buffers on the bus keep going; they are caught after lost arb or error
    // a buffer finishing in the abort cycle counts as sent, not aborted
    wire [2:0] abortable = req_q & ~tx_active_in & ~tx_done_in;
    wire [2:0] abort_now = abort_req ? abortable : 3'h0;
    wire [2:0] sw_clear  = wr_txc ? (req_q & ~wdata_in[2:0]) : 3'h0;
    wire [2:0] sw_set    = wr_txc ? wdata_in[2:0] : 3'h0;
    wire [2:0] req_d     = (req_q & ~sw_clear & ~abort_now & ~tx_done_in)
                           | sw_set;
    // abort stays pending while any requested buffer is still on the bus
    wire abort_pend_d = abort_req && |(req_q & tx_active_in);

    // ----------------------------------------------------------------
    // error counter
    // ----------------------------------------------------------------
    function automatic logic [8:0] sat_inc(input logic [8:0] v);
        sat_inc = (v == 9'h1FF) ? v : v + 9'h001;
    endfunction : sat_inc

    // ninth bit lets the count pass 255 so bus off is reachable
    wire [8:0] cnt_d = wr_cnt ? {1'b0, wdata_in[7:0]}
                     : (tx_err_in ? sat_inc(err_cnt_q) : err_cnt_q);
    wire warn_ev    = cnt_d > cbt_pkg::WARN_LIMIT;
    wire passive_ev = cnt_d > cbt_pkg::PASSIVE_LIMIT;
    wire busoff_ev  = cnt_d > cbt_pkg::BUS_OFF_LIMIT;

    // flags clear by writing one; a set in the same cycle wins
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic clr);
        flag_next = set || (cur && !clr);
    endfunction : flag_next

    wire [2:0] free_bufs = ~req_d;
    wire [2:0] newly_free = free_bufs & (req_q & ~abort_now);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ctrl_q       <= 16'h0000;
            cfg1_q       <= cbt_pkg::CFG1_RESET;
            cfg2_q       <= cbt_pkg::CFG2_RESET;
            req_q        <= 3'h0;
            abort_pend_q <= 1'b0;
            err_cnt_q    <= 9'h000;
            div4_q       <= 1'b1;
        end else if (enable_in) begin
            if (wr_ctrl)
                ctrl_q <= wdata_in & ~(16'h0001 << cbt_pkg::ABORT_ALL_BIT);
            if (wr_ctrl)
                div4_q <= !wdata_in[cbt_pkg::CLK_SEL_BIT];
            if (wr_cfg1)
                cfg1_q <= wdata_in;
            if (wr_cfg2)
                cfg2_q <= wdata_in;
            req_q        <= req_d;
            abort_pend_q <= abort_pend_d;
            err_cnt_q    <= cnt_d;
        end
    end

    // every flag computed on its own so coincident events all land
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            aborted_q <= 3'h0;
            bufirq_q  <= 3'h0;
            err_irq_q <= 1'b0;
            warn_q    <= 1'b0;
            passive_q <= 1'b0;
            bus_off_q <= 1'b0;
        end else if (enable_in) begin
            for (int i = 0; i < cbt_pkg::NUM_TX_BUFS; i++) begin
                aborted_q[i] <= flag_next(aborted_q[i], abort_now[i],
                    wr_txs && wdata_in[cbt_pkg::ABORTED_LSB+i]);
                bufirq_q[i]  <= flag_next(bufirq_q[i], newly_free[i],
                    wr_txs && wdata_in[cbt_pkg::BUF_IRQ_LSB+i]);
            end
            err_irq_q <= flag_next(err_irq_q, warn_ev,
                wr_flags && wdata_in[cbt_pkg::ERR_IRQ_BIT]);
            warn_q    <= flag_next(warn_q, warn_ev,
                wr_flags && wdata_in[cbt_pkg::TX_WARN_BIT]);
            passive_q <= flag_next(passive_q, passive_ev,
                wr_flags && wdata_in[cbt_pkg::TX_PASSIVE_BIT]);
            bus_off_q <= flag_next(bus_off_q, busoff_ev,
                wr_flags && wdata_in[cbt_pkg::BUS_OFF_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    wire [15:0] flag_word = (16'(err_irq_q) << cbt_pkg::ERR_IRQ_BIT)
                          | (16'(warn_q) << cbt_pkg::TX_WARN_BIT)
                          | (16'(passive_q) << cbt_pkg::TX_PASSIVE_BIT)
                          | (16'(bus_off_q) << cbt_pkg::BUS_OFF_BIT);
    wire [15:0] txs_word  = (16'(aborted_q) << cbt_pkg::ABORTED_LSB)
                          | (16'(bufirq_q) << cbt_pkg::BUF_IRQ_LSB);
    wire [15:0] rd_mux =
        addr_in == cbt_pkg::ADDR_MODULE_CONTROL ? ctrl_q :
        addr_in == cbt_pkg::ADDR_INT_FLAG       ? flag_word :
        addr_in == cbt_pkg::ADDR_TIMING_CONFIG1 ? cfg1_q :
        addr_in == cbt_pkg::ADDR_TIMING_CONFIG2 ? cfg2_q :
        addr_in == cbt_pkg::ADDR_TX_CONTROL     ? {13'h0000, req_q} :
        addr_in == cbt_pkg::ADDR_TX_STATUS      ? txs_word :
        addr_in == cbt_pkg::ADDR_ERR_COUNT      ? {7'h00, err_cnt_q} : 16'h0000;

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_q  <= 16'h0000;
            tx_irq_q <= 1'b0;
        end else if (enable_in) begin
            rdata_q  <= read_in ? rd_mux : 16'h0000;
            tx_irq_q <= |bufirq_q;
        end
    end

    // ----------------------------------------------------------------
    // segment lengths
    // ----------------------------------------------------------------
    wire [4:0] prop_len = {2'h0, cfg2_q[cbt_pkg::PROP_LSB +: 3]} + 5'h01;
    wire [4:0] ph1_len  = {2'h0, cfg2_q[cbt_pkg::PH1_LSB +: 3]} + 5'h01;
    wire [4:0] ph2_prog = {2'h0, cfg2_q[cbt_pkg::PH2_LSB +: 3]} + 5'h01;
    wire [4:0] ph2_auto = (ph1_len > cbt_pkg::PROC_TQ) ? ph1_len : cbt_pkg::PROC_TQ;
    wire [4:0] ph2_len  = cfg2_q[cbt_pkg::PH2_FREE_BIT] ? ph2_prog : ph2_auto;
    wire [4:0] jump_width      = {3'h0, cfg1_q[cbt_pkg::JUMP_LSB +: 2]} + 5'h01;
    wire [5:0] presc    = cfg1_q[cbt_pkg::PRESC_LSB +: 6];
    wire [4:0] raw_bit  = 5'h01 + prop_len + ph1_len + ph2_len;
    // short settings are stretched in phase two; long ones trim phase two
    wire [4:0] bit_len  = raw_bit < cbt_pkg::MIN_BIT_TQ ? cbt_pkg::MIN_BIT_TQ :
                          raw_bit > cbt_pkg::MAX_BIT_TQ ? cbt_pkg::MAX_BIT_TQ :
                          raw_bit;
    wire [4:0] seg1_end = 5'h01 + prop_len + ph1_len;

    // ----------------------------------------------------------------
    // rx pin synchroniser and edge
    // ----------------------------------------------------------------
    logic [2:0] rx_sync_q;
    logic       rx_stable_q;
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rx_sync_q   <= 3'h7;
            rx_stable_q <= 1'b1;
        end else if (enable_in) begin
            rx_sync_q <= {rx_sync_q[1:0], rx_pin_in};
            if (rx_sync_q[2] == rx_sync_q[1])
                rx_stable_q <= rx_sync_q[1];
        end
    end
    wire fall_edge = rx_stable_q && rx_sync_q[2] == rx_sync_q[1] && !rx_sync_q[1];
    wire any_edge  = rx_sync_q[2] == rx_sync_q[1] && rx_sync_q[1] != rx_stable_q;

    // ----------------------------------------------------------------
    // bit timing engine
    // ----------------------------------------------------------------
    logic [4:0] tq_q;
    logic [4:0] ext_q;
    logic [4:0] cut_q;
    logic       hard_q;
    logic [1:0] samp_q;
    logic       rx_bit_q;
    logic       samp_tick_q;
    logic       half_tick;
    logic       tq_tick;

    wire hard_sync = bus_idle_in && fall_edge && !hard_q;
    wire in_sync   = tq_q == 5'h00;
    wire [4:0] sample_at = seg1_end + ext_q;
    wire [4:0] end_at    = bit_len + ext_q - cut_q;
    wire late_edge  = any_edge && !in_sync && tq_q < sample_at;
    wire early_edge = any_edge && !in_sync && tq_q >= sample_at;
    wire resync_ok  = !hard_q && !hard_sync && !bus_idle_in;
    wire [4:0] late_amt  = (tq_q < jump_width) ? tq_q : jump_width;
    wire [4:0] early_rem = end_at - tq_q;
    wire [4:0] early_amt = (early_rem < jump_width) ? early_rem : jump_width;

    cbt_prescaler u_presc (
        .clock_in      (clock_in),
        .reset_in      (reset_in),
        .enable_in     (enable_in),
        .restart_in    (hard_sync),
        .presc_in      (presc),
        .half_tick_out (half_tick),
        .tq_tick_out   (tq_tick)
    );

    wire bit_end  = tq_tick && (tq_q + 5'h01 >= end_at);
    // three samples spaced half a quantum, the last at the sample point
    wire near_smp = half_tick && (tq_q + 5'h02 >= sample_at) && (tq_q < sample_at);
    wire at_smp   = tq_tick && (tq_q + 5'h01 == sample_at);
    wire majority = (samp_q[0] & samp_q[1]) | (samp_q[1] & rx_stable_q)
                  | (samp_q[0] & rx_stable_q);

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            tq_q        <= 5'h00;
            ext_q       <= 5'h00;
            cut_q       <= 5'h00;
            hard_q      <= 1'b0;
            samp_q      <= 2'h3;
            rx_bit_q    <= 1'b1;
            samp_tick_q <= 1'b0;
        end else if (enable_in) begin
            samp_tick_q <= at_smp;
            if (hard_sync) begin
                tq_q   <= 5'h00;
                ext_q  <= 5'h00;
                cut_q  <= 5'h00;
                hard_q <= 1'b1;
            end else begin
                if (late_edge && resync_ok)
                    ext_q <= late_amt;
                if (early_edge && resync_ok)
                    cut_q <= early_amt;
                if (bit_end) begin
                    tq_q   <= 5'h00;
                    ext_q  <= 5'h00;
                    cut_q  <= 5'h00;
                    hard_q <= 1'b0;
                end else if (tq_tick) begin
                    tq_q <= tq_q + 5'h01;
                end
            end
            if (near_smp)
                samp_q <= {samp_q[0], rx_stable_q};
            if (at_smp)
                rx_bit_q <= cfg2_q[cbt_pkg::TRIPLE_BIT] ? majority
                                                        : rx_stable_q;
        end
    end

    assign rdata_out        = rdata_q;
    assign tx_request_out   = req_q;
    assign tx_irq_out       = tx_irq_q;
    assign err_irq_out      = err_irq_q;
    assign sample_tick_out  = samp_tick_q;
    assign rx_bit_out       = rx_bit_q;
    assign clk_div4_sel_out = div4_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    AST_ABORT_CLEARS: assert property (enable_in && abort_all_wr && |abortable
        |=> |aborted_q) else $error("abort did not flag");
    AST_ACTIVE_KEPT: assert property (enable_in && abort_now != 3'h0
        |-> (abort_now & tx_active_in) == 3'h0) else $error("active aborted");
    AST_NO_IRQ_ON_ABORT: assert property (enable_in && abort_now[0] && !bufirq_q[0]
        && !tx_done_in[0] |=> !bufirq_q[0]) else $error("irq on abort");
    AST_INC_ONE: assert property (enable_in && tx_err_in && !wr_cnt && err_cnt_q < 9'h1FF
        |=> err_cnt_q == $past(err_cnt_q) + 9'h001) else $error("bad increment");
    AST_WARN: assert property (enable_in && cnt_d > 9'h060 |=> warn_q && err_irq_q)
        else $error("warn missing");
    AST_PASSIVE: assert property (enable_in && cnt_d > 9'h07F |=> passive_q)
        else $error("passive missing");
    AST_BUSOFF: assert property (enable_in && cnt_d > 9'h0FF |=> bus_off_q)
        else $error("bus off missing");
    AST_BIT_RANGE: assert property (bit_len >= 5'h08 && bit_len <= 5'h19)
        else $error("bit length range");
    AST_HARD_RESTART: assert property (enable_in && hard_sync |=> tq_q == 5'h00 && hard_q)
        else $error("hard sync no restart");
    AST_NO_RESYNC: assert property (enable_in && hard_q && !bit_end |=> ext_q == 5'h00
        && cut_q == 5'h00) else $error("resync after hard sync");
    AST_SJW: assert property (ext_q <= jump_width && cut_q <= jump_width)
        else $error("jump too wide");
    COV_ABORT: cover property (enable_in && abort_all_wr && |abortable);
    COV_BUSOFF: cover property (bus_off_q);
    COV_HARD: cover property (enable_in && hard_sync);
    COV_RESYNC: cover property (enable_in && late_edge && resync_ok);
endmodule : cbt_core
`default_nettype wire

// ---- cbt_node_model.sv ----
// far-side can node model: bus traffic, completion and error events
`timescale 1ns/1ps
`default_nettype none
module cbt_node_model (
    input  wire logic       clock_in,
    input  wire logic       frame_in,
    input  wire logic       err_cmd_in,
    input  wire logic [2:0] active_cmd_in,
    input  wire logic [2:0] done_cmd_in,
    output logic            rx_pin_out,
    output logic            bus_idle_out,
    output logic            tx_err_out,
    output logic [2:0]      tx_active_out,
    output logic [2:0]      tx_done_out
);
    logic [3:0] idle_q = 4'hF;
    initial begin
        rx_pin_out = 1'b1;
        bus_idle_out = 1'b1;
        tx_err_out = 1'b0;
        tx_active_out = 3'h0;
        tx_done_out = 3'h0;
    end
    // idle lags the pin past the receiver's synchroniser, so the falling
    // edge still meets an idle bus
    always @(posedge clock_in) begin
        rx_pin_out    <= ~frame_in;
        idle_q        <= {idle_q[2:0], rx_pin_out};
        bus_idle_out  <= idle_q[3];
        tx_err_out    <= err_cmd_in;
        tx_active_out <= active_cmd_in;
        tx_done_out   <= done_cmd_in;
    end
endmodule : cbt_node_model
`default_nettype wire

// ---- cbt_pkg.sv ----
// shared constants for the can transmit error and bit timing block
package cbt_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_MODULE_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_INT_FLAG       = 4'h1;
    localparam logic [3:0] ADDR_TIMING_CONFIG1 = 4'h2;
    localparam logic [3:0] ADDR_TIMING_CONFIG2 = 4'h3;
    localparam logic [3:0] ADDR_TX_CONTROL     = 4'h4;
    localparam logic [3:0] ADDR_TX_STATUS      = 4'h5;
    localparam logic [3:0] ADDR_ERR_COUNT      = 4'h6;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int ABORT_ALL_BIT   = 12;
    localparam int CLK_SEL_BIT     = 11;
    localparam int ERR_IRQ_BIT     = 5;
    localparam int TX_WARN_BIT     = 10;
    localparam int TX_PASSIVE_BIT  = 12;
    localparam int BUS_OFF_BIT     = 13;
    localparam int TRIPLE_BIT      = 6;
    localparam int PROP_LSB        = 0;
    localparam int PH1_LSB         = 3;
    localparam int PH2_LSB         = 8;
    localparam int PH2_FREE_BIT    = 7;
    localparam int PRESC_LSB       = 0;
    localparam int JUMP_LSB        = 6;
    localparam int REQ_LSB         = 0;
    localparam int ABORTED_LSB     = 4;
    localparam int BUF_IRQ_LSB     = 8;
    // ----------------------------------------------------------------
    // limits and reset values
    // ----------------------------------------------------------------
    localparam int NUM_TX_BUFS      = 3;
    localparam logic [8:0] WARN_LIMIT    = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUS_OFF_LIMIT = 9'h0FF;
    localparam logic [15:0] CFG1_RESET   = 16'h0000;
    localparam logic [15:0] CFG2_RESET   = 16'h0000;
    localparam int IDLE_BITS        = 11;
    localparam logic [4:0] MIN_BIT_TQ = 5'h08;
    localparam logic [4:0] MAX_BIT_TQ = 5'h19;
    localparam logic [4:0] PROC_TQ    = 5'h02;
endpackage : cbt_pkg

// ---- cbt_prescaler.sv ----
// time quantum prescaler: half-quantum ticks from the module clock
`timescale 1ns/1ps
`default_nettype none
module cbt_prescaler (
    input  wire logic       clock_in,
    input  wire logic       reset_in,
    input  wire logic       enable_in,
    input  wire logic       restart_in,
    input  wire logic [5:0] presc_in,
    output logic            half_tick_out,
    output logic            tq_tick_out
);
    logic [5:0] cnt_q;
    logic       phase_q;
    // a divisor lowered mid-count must not let the count run past it
    wire        wrap = (cnt_q >= presc_in);

    // two half quanta of (presc+1) clocks each: tq = 2*(presc+1) clocks
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cnt_q   <= 6'h00;
            phase_q <= 1'b0;
        end else if (enable_in) begin
            if (restart_in) begin
                cnt_q   <= 6'h00;
                phase_q <= 1'b0;
            end else begin
                cnt_q <= wrap ? 6'h00 : cnt_q + 6'h01;
                if (wrap)
                    phase_q <= ~phase_q;
            end
        end
    end

    assign half_tick_out = enable_in && wrap && !restart_in;
    assign tq_tick_out   = half_tick_out && phase_q;
endmodule : cbt_prescaler
`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the can transmit error and bit timing block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [3:0]  addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000;
    logic        write_in = 1'b0;
    logic        read_in = 1'b0;
    logic        frame = 1'b0;
    logic        err_cmd = 1'b0;
    logic [2:0]  active_cmd = 3'h0;
    logic [2:0]  done_cmd = 3'h0;
    logic        en = 1'b1;
    wire logic [15:0] rdata_out;
    wire logic        rx_pin, bus_idle, tx_err, tx_irq_out, err_irq_out;
    wire logic        sample_tick_out, rx_bit_out, clk_div4_sel_out;
    wire logic [2:0]  tx_active, tx_done, tx_request_out;
    int          n_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    int          t, t0, t1, e;
    logic [15:0] c1 [4] = '{16'h0001, 16'h0001, 16'h0002, 16'h0001};
    logic [15:0] c2 [4] = '{16'h0000, 16'h0290, 16'h0290, 16'h07FF};
    logic [15:0] ex [4] = '{16'h0020, 16'h0020, 16'h0030, 16'h0064};

    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;

    cbt_core i_dut (.clock_in(clock_in), .reset_in(reset_in), .enable_in(en),
        .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
        .rdata_out(rdata_out), .rx_pin_in(rx_pin), .tx_active_in(tx_active),
        .tx_done_in(tx_done), .tx_err_in(tx_err), .bus_idle_in(bus_idle),
        .tx_request_out(tx_request_out), .tx_irq_out(tx_irq_out), .err_irq_out(err_irq_out),
        .sample_tick_out(sample_tick_out), .rx_bit_out(rx_bit_out),
        .clk_div4_sel_out(clk_div4_sel_out));
    cbt_node_model i_node (.clock_in(clock_in), .frame_in(frame), .err_cmd_in(err_cmd),
        .active_cmd_in(active_cmd), .done_cmd_in(done_cmd), .rx_pin_out(rx_pin),
        .bus_idle_out(bus_idle), .tx_err_out(tx_err), .tx_active_out(tx_active),
        .tx_done_out(tx_done));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clock_in);
    endtask : w
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr_in  <= a;
        wdata_in <= d;
        write_in <= 1'b1;
        @(posedge clock_in);
        write_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock_in);
        addr_in <= a;
        read_in <= 1'b1;
        @(posedge clock_in);
        read_in <= 1'b0;
        @(negedge clock_in);
        chk(rdata_out, exp);
    endtask : rd
    // bounded wait for the next sample pulse, returns its cycle
    task automatic tick(output int tt);
        int k;
        k = 0;
        @(negedge clock_in);
        while (sample_tick_out !== 1'b1 && k < 400) begin
            @(negedge clock_in);
            k++;
        end
        tt = cyc;
        if (k >= 400) begin
            n_errors++;
            $display("[FAIL] %0t no sample tick", $time);
        end
    endtask : tick
    task automatic err1();
        @(posedge clock_in);
        err_cmd <= 1'b1;
        @(posedge clock_in);
        err_cmd <= 1'b0;
        w(3);
    endtask : err1
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    initial begin
        #1000000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        w(20);
        reset_in <= 1'b0;
        rd(cbt_pkg::ADDR_TX_STATUS, 16'h0000);
        rd(4'hF, 16'h0000);
        chk({15'h0000, rx_bit_out}, 16'h0001);
        chk({15'h0000, clk_div4_sel_out}, 16'h0001);
        wr(cbt_pkg::ADDR_MODULE_CONTROL, 16'h0800);
        w(2);
        chk({15'h0000, clk_div4_sel_out}, 16'h0000);
        // clock enable low must swallow a write
        en <= 1'b0;
        wr(cbt_pkg::ADDR_TX_CONTROL, 16'h0007);
        en <= 1'b1;
        w(2);
        chk({13'h0000, tx_request_out}, 16'h0000);
        wr(cbt_pkg::ADDR_TX_CONTROL, 16'h0007);
        w(2);
        chk({13'h0000, tx_request_out}, 16'h0007);
        wr(cbt_pkg::ADDR_TX_CONTROL, 16'h0006);
        w(3);
        chk({13'h0000, tx_request_out}, 16'h0006);
        chk({15'h0000, tx_irq_out}, 16'h0001);
        wr(cbt_pkg::ADDR_MODULE_CONTROL, 16'h1800);
        w(3);
        chk({13'h0000, tx_request_out}, 16'h0000);
        rd(cbt_pkg::ADDR_TX_STATUS, 16'h0160);
        wr(cbt_pkg::ADDR_TX_STATUS, 16'hFFFF);
        w(2);
        chk({15'h0000, tx_irq_out}, 16'h0000);
        active_cmd <= 3'h3;
        wr(cbt_pkg::ADDR_TX_CONTROL, 16'h0003);
        wr(cbt_pkg::ADDR_MODULE_CONTROL, 16'h1800);
        w(3);
        chk({13'h0000, tx_request_out}, 16'h0003);
        done_cmd <= 3'h1;
        active_cmd <= 3'h0;
        @(posedge clock_in);
        done_cmd <= 3'h0;
        w(3);
        chk({13'h0000, tx_request_out}, 16'h0000);
        rd(cbt_pkg::ADDR_TX_STATUS, 16'h0120);
        // slow configs only: bit time stays at or above one microsecond
        for (int i = 0; i < 4; i++) begin
            wr(cbt_pkg::ADDR_TIMING_CONFIG1, c1[i]);
            wr(cbt_pkg::ADDR_TIMING_CONFIG2, c2[i]);
            rd(cbt_pkg::ADDR_TIMING_CONFIG2, c2[i]);
            tick(t);
            tick(t0);
            tick(t1);
            chk(16'(t1 - t0), ex[i]);
        end
        @(posedge clock_in);
        frame <= 1'b1;
        e = cyc;
        tick(t);
        chk({15'h0000, (t - e >= 60 && t - e <= 76)}, 16'h0001);
        tick(t0);
        chk({15'h0000, rx_bit_out}, 16'h0000);
        @(posedge clock_in);
        frame <= 1'b0;
        wr(cbt_pkg::ADDR_ERR_COUNT, 16'h0060);
        w(2);
        rd(cbt_pkg::ADDR_INT_FLAG, 16'h0000);
        err1();
        rd(cbt_pkg::ADDR_ERR_COUNT, 16'h0061);
        rd(cbt_pkg::ADDR_INT_FLAG, 16'h0420);
        chk({15'h0000, err_irq_out}, 16'h0001);
        wr(cbt_pkg::ADDR_ERR_COUNT, 16'h007F);
        rd(cbt_pkg::ADDR_INT_FLAG, 16'h0420);
        err1();
        rd(cbt_pkg::ADDR_INT_FLAG, 16'h1420);
        wr(cbt_pkg::ADDR_ERR_COUNT, 16'h00FF);
        err1();
        rd(cbt_pkg::ADDR_ERR_COUNT, 16'h0100);
        rd(cbt_pkg::ADDR_INT_FLAG, 16'h3420);
        summarize();
    end
endmodule : tb
`default_nettype wire
